//--- rtl/snf_pkg.sv
package snf_pkg;
  localparam int OP_W = 8;
  localparam int PAGE_W = 16;
  localparam int LVL_W = 4;
  localparam int BLK_SH = 6;
  localparam int MAX_LVL = 9;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_READ_STAT_A = 8'h0F;
  localparam logic [7:0] OP_READ_STAT_B = 8'h05;
  localparam logic [7:0] OP_WR_STAT_A = 8'h1F;
  localparam logic [7:0] OP_WR_STAT_B = 8'h01;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
  localparam logic [7:0] OP_PROT_ADDR = 8'hA0;
  localparam int ID_BYTES = 3;
  localparam int CMD_BYTES = 4;
  localparam logic [15:0] PAGE_ALL = 16'hFFFF;
  localparam logic [15:0] PAGE_ZERO = 16'h0000;
  typedef enum {SNF_IDLE, SNF_SHIFT} snf_frame_t;
endpackage

//--- rtl/snf_xfer_if.sv
`timescale 1ns/1ps
interface snf_xfer_if;
  logic frameTgl;
  logic [31:0] frameWord;
  logic [5:0] frameBits;
  logic [7:0] frameOp;
  logic [7:0] statusByte;
  modport link (output frameTgl, output frameWord, output frameBits, output frameOp,
    input statusByte);
  modport core (input frameTgl, input frameWord, input frameBits, input frameOp,
    output statusByte);
endinterface

//--- rtl/snf_link.sv
`timescale 1ns/1ps
module snf_link
  import snf_pkg::*;
(
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialDataIn,
  input wire logic [23:0] idWord,
  output logic serialDataOut,
  output logic serialDataOutEnN,
  snf_xfer_if.link xf
);
  logic [31:0] shiftIn;
  logic [5:0] bitCnt;
  logic [31:0] outShift;
  logic [7:0] opByte;
  logic busy1;
  logic busy2;
  wire opDone = (bitCnt == 6'(OP_W));
  wire opLast = (bitCnt == 6'(OP_W - 1));
  wire isId = (opByte == OP_READ_ID);
  // only the busy bit moves; the upper status bits are constant
  wire [7:0] statReply = {xf.statusByte[7:1], busy2};
  // a dummy byte leads the codes
  wire [31:0] reply = isId ? {8'h00, idWord} : {4{statReply}};
  // cs high acts as async reset: clock only runs inside frames
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      shiftIn <= '0;
      bitCnt <= '0;
      opByte <= '0;
    end else begin
      shiftIn <= {shiftIn[30:0], serialDataIn};
      bitCnt <= (bitCnt == 6'd63) ? bitCnt : bitCnt + 6'd1;
      // opcode kept apart so long frames cannot push it out of the word
      if (opLast) begin
        opByte <= {shiftIn[6:0], serialDataIn};
      end
    end
  end
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      busy1 <= 1'b0;
      busy2 <= 1'b0;
    end else begin
      busy1 <= xf.statusByte[0];
      busy2 <= busy1;
    end
  end
  // output shifts on falling edge; read stops cleanly whenever cs rises
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      outShift <= '0;
      serialDataOutEnN <= 1'b1;
      serialDataOut <= 1'b0;
    end else if (opDone) begin
      // first reply bit goes out on the fall right after the opcode
      serialDataOutEnN <= 1'b0;
      serialDataOut <= reply[31];
      outShift <= {reply[30:0], reply[31]};
    end else if (!serialDataOutEnN) begin
      serialDataOut <= outShift[31];
      outShift <= {outShift[30:0], outShift[31]};
    end
  end
  // frame content captured at cs rise, flagged by toggle to core domain
  always_ff @(posedge csN or negedge rst_n) begin
    if (!rst_n) begin
      xf.frameWord <= '0;
      xf.frameBits <= '0;
      xf.frameOp <= '0;
      xf.frameTgl <= 1'b0;
    end else begin
      xf.frameWord <= shiftIn;
      xf.frameBits <= bitCnt;
      xf.frameOp <= opByte;
      xf.frameTgl <= ~xf.frameTgl;
    end
  end
endmodule

//--- rtl/snf_frontend.sv
`timescale 1ns/1ps
// Operation
// - level and bottom bit select protected blocks
// - protected program or erase target is ignored
// - chip select fall starts a frame
// - first eight bits are the opcode
// - sample rising edge, msb first
// - opcode followed by address, data or dummy
// - chip select rise completes the instruction
// - reads may end after any bit
// - modifying commands need whole bytes
// - busy high during internal operations
// - busy ignores all but status and id; a partial modifying frame still raises byteErr
// - id read returns maker and part codes
module snf_frontend
  import snf_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234 // arbitrary value
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutEnN,
  input wire logic arrayBusy,
  output logic busy,
  output logic progReq,
  output logic eraseReq,
  output logic [15:0] pageRowAddress,
  output logic protectReject,
  output logic byteErr,
  output logic bottomSelect,
  output logic [3:0] protectLevel,
  output logic [15:0] protLo,
  output logic [15:0] protHi
);
  import snf_pkg::*;
  snf_xfer_if xf();
  logic [7:0] statusByte;
  snf_link uLink (
    .rst_n(rst_n),
    .sclk(sclk),
    .csN(csN),
    .serialDataIn(serialDataIn),
    .idWord({MAKER_CODE, PART_CODE}),
    .serialDataOut(serialDataOut),
    .serialDataOutEnN(serialDataOutEnN),
    .xf(xf)
  );
  assign xf.statusByte = statusByte;
  logic t1, t2, t3;
  logic busyS1, busyS2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t1 <= 1'b0;
      t2 <= 1'b0;
      t3 <= 1'b0;
      busyS1 <= 1'b0;
      busyS2 <= 1'b0;
    end else begin
      t1 <= xf.frameTgl;
      t2 <= t1;
      t3 <= t2;
      busyS1 <= arrayBusy;
      busyS2 <= busyS1;
    end
  end
  wire frameEv = t2 ^ t3;
  // word is stable well before toggle reaches t2
  wire [31:0] fw = xf.frameWord;
  wire [5:0] nb = xf.frameBits;
  wire [7:0] op = xf.frameOp;
  wire wholeBytes = (nb[2:0] == 3'd0) && (nb != 6'd0);
  wire isProg = (op == OP_PROG_EXEC);
  wire isErase = (op == OP_BLK_ERASE);
  wire isWrStat = (op == OP_WR_STAT_A) || (op == OP_WR_STAT_B);
  wire modifying = isProg || isErase || isWrStat;
  wire [15:0] pageArg = fw[15:0];
  wire [3:0] lvl = protectLevel;
  wire [4:0] shAmt = (lvl > 4'(MAX_LVL)) ? 5'(PAGE_W) : 5'(lvl) + 5'(BLK_SH);
  wire [16:0] span = (lvl == 4'd0) ? 17'd0 : (17'd1 << shAmt);
  assign protLo = (lvl > 4'(MAX_LVL)) ? PAGE_ZERO :
    bottomSelect ? PAGE_ZERO : 16'((17'd1 << PAGE_W) - span);
  assign protHi = (lvl > 4'(MAX_LVL)) ? PAGE_ALL :
    bottomSelect ? 16'(span - 17'd1) : PAGE_ALL;
  wire anyProt = (lvl != 4'd0);
  // erase hits a whole block, so its full page span is checked
  wire [15:0] blkMask = ~16'((17'd1 << BLK_SH) - 17'd1);
  wire [15:0] tgtLo = isErase ? (pageArg & blkMask) : pageArg;
  wire [15:0] tgtHi = isErase ? (pageArg | ~blkMask) : pageArg;
  wire hitProt = anyProt && (tgtHi >= protLo) && (tgtLo <= protHi);
  wire busyNow = busyS2;
  wire accept = frameEv && modifying && wholeBytes && !busyNow;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      progReq <= 1'b0;
      eraseReq <= 1'b0;
      protectReject <= 1'b0;
      byteErr <= 1'b0;
      pageRowAddress <= '0;
      bottomSelect <= 1'b0;
      protectLevel <= '0;
    end else begin
      progReq <= accept && isProg && !hitProt;
      eraseReq <= accept && isErase && !hitProt;
      protectReject <= accept && (isProg || isErase) && hitProt;
      byteErr <= frameEv && modifying && !wholeBytes;
      if (accept && (isProg || isErase) && !hitProt) begin
        pageRowAddress <= pageArg;
      end
      if (accept && isWrStat && fw[15:8] == OP_PROT_ADDR) begin
        bottomSelect <= fw[2];
        protectLevel <= fw[6:3];
      end
    end
  end
  assign busy = busyNow;
  assign statusByte = {7'h00, busyNow};
endmodule

//--- dv/snf_frontend_props.sv
`timescale 1ns/1ps
module snf_frontend_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arrayBusy,
  input wire logic busy,
  input wire logic progReq,
  input wire logic eraseReq,
  input wire logic [15:0] pageRowAddress,
  input wire logic protectReject,
  input wire logic byteErr,
  input wire logic bottomSelect,
  input wire logic [3:0] protectLevel,
  input wire logic [15:0] protLo,
  input wire logic [15:0] protHi
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_top_one: assert property (
    !bottomSelect && protectLevel == 4'h1 |-> protLo == 16'hFF80 && protHi == 16'hFFFF)
    else $error("top range");
  chk_bottom_nine: assert property (
    bottomSelect && protectLevel == 4'h9 |-> protLo == 16'h0000 && protHi == 16'h7FFF)
    else $error("bottom range");
  chk_all_high: assert property (
    protectLevel >= 4'hA |-> protLo == 16'h0000 && protHi == 16'hFFFF) else $error("all range");
  chk_req_outside: assert property (
    progReq || eraseReq |-> protectLevel == 4'h0 || pageRowAddress < protLo
      || pageRowAddress > protHi) else $error("protected request");
  chk_refuse_quiet: assert property (
    byteErr || protectReject |-> !progReq && !eraseReq) else $error("refused yet issued");
  chk_busy_sync: assert property (
    $past(rst_n, 2) |-> busy == $past(arrayBusy, 2)) else $error("busy lag");
  chk_busy_block: assert property (
    busy |-> !progReq && !eraseReq) else $error("request while busy");
  chk_pulse_once: assert property (
    progReq || eraseReq |=> !progReq && !eraseReq) else $error("long pulse");
endmodule
bind snf_frontend snf_frontend_props chk_u (.*);

//--- dv/snf_host_model.sv
`timescale 1ns/1ps
module snf_host_model (
  output logic sclk,
  output logic csN,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  logic [31:0] rx = 32'h0000_0000;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    serialDataIn = 1'b0;
  end
  // clock stands still between frames
  task automatic xfer(input logic [31:0] w, input int n);
    logic [63:0] wx;
    // frames longer than the word trail zero bits
    wx = {32'h0000_0000, w} << ((n > 32) ? n - 32 : 0);
    csN = 1'b0;
    #6;
    for (int i = n - 1; i >= 0; i--) begin
      serialDataIn = wx[i];
      #3 sclk = 1'b1;
      rx = {rx[30:0], serialDataOut};
      #3 sclk = 1'b0;
    end
    #3 csN = 1'b1;
    serialDataIn = ~serialDataIn;
  endtask
endmodule

//--- dv/serial_nand_cmd_frontend_protect_test.sv
`timescale 1ns/1ps
module serial_nand_cmd_frontend_protect_test;
  import snf_pkg::*;
  localparam logic [7:0] MK = 8'h3C; // arbitrary
  localparam logic [15:0] PT = 16'h0A5E; // arbitrary
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic arrayBusy = 1'b0;
  logic sclk, csN, sdi, sdo, enN, busy, pr, er, rej, bErr, bot;
  logic [3:0] lvl, ev;
  logic [15:0] pa, lo, hi, sz;
  int err_count = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  snf_host_model host_u (.sclk(sclk), .csN(csN), .serialDataIn(sdi), .serialDataOut(sdo));
  snf_frontend #(.MAKER_CODE(MK), .PART_CODE(PT)) dut_u (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .csN(csN), .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOutEnN(enN),
    .arrayBusy(arrayBusy), .busy(busy), .progReq(pr), .eraseReq(er), .pageRowAddress(pa),
    .protectReject(rej), .byteErr(bErr), .bottomSelect(bot), .protectLevel(lvl),
    .protLo(lo), .protHi(hi));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // collect pulses over a span longer than the crossing
  task automatic frame(input logic [31:0] w, input int n);
    host_u.xfer(w, n);
    ev = 4'h0;
    repeat (20) begin
      @(posedge clk);
      #1 ev = ev | {pr, er, rej, bErr};
    end
  endtask
  task automatic t_id();
    frame({OP_READ_ID, 24'h00_0000}, 40);
    chk("id", host_u.rx, {8'h00, MK, PT});
    $display("end id");
  endtask
  task automatic t_prot();
    logic [31:0] rngExp;
    for (int l = 0; l < 16; l++) for (int b = 0; b < 2; b++) begin
      frame({8'h00, OP_WR_STAT_A, OP_PROT_ADDR, 1'b0, l[3:0], b[0], 2'b00}, 24);
      sz = 16'h0080 << (l - 1);
      rngExp = b ? {16'h0000, sz - 16'h0001} : {~sz + 16'h0001, 16'hFFFF};
      chk("lvl", {bot, lvl}, {b[0], l[3:0]});
      if (l >= 10) chk("all", {lo, hi}, 32'h0000_FFFF);
      else if (l > 0) chk("rng", {lo, hi}, rngExp);
    end
    $display("end protect");
  endtask
  task automatic t_prog();
    frame({8'h00, OP_WR_STAT_A, OP_PROT_ADDR, 8'h18}, 24);
    frame({OP_PROG_EXEC, 8'h00, 16'hFDFF}, 32);
    chk("prog", {ev, pa}, {4'h8, 16'hFDFF});
    frame({OP_PROG_EXEC, 8'h00, 16'hFE00}, 32);
    chk("prog_prot", ev, 4'h2);
    frame({OP_BLK_ERASE, 8'h00, 16'hFDC0}, 32);
    chk("erase", {ev, pa}, {4'h4, 16'hFDC0});
    frame({OP_BLK_ERASE, 8'h00, 16'hFFC0}, 32);
    chk("erase_prot", ev, 4'h2);
    frame({1'b0, OP_PROG_EXEC, 8'h00, 15'h0080}, 31);
    chk("partial", ev, 4'h1);
    $display("end program");
  endtask
  task automatic t_abort();
    frame({19'h0_0000, OP_READ_ID, 5'h00}, 13);
    chk("abort", ev, 4'h0);
    chk("release", enN, 1'b1);
    t_id();
    $display("end abort");
  endtask
  task automatic t_busy();
    arrayBusy <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("busy", busy, 1'b1);
    frame({OP_PROG_EXEC, 8'h00, 16'h0000}, 32);
    chk("busy_prog", ev, 4'h0);
    t_id();
    frame({OP_READ_STAT_A, 24'h00_0000}, 40);
    chk("stat_busy", host_u.rx, 32'h0101_0101);
    @(posedge clk) arrayBusy <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("idle", busy, 1'b0);
    frame({OP_READ_STAT_A, 24'h00_0000}, 40);
    chk("stat_idle", host_u.rx, 32'h0000_0000);
    $display("end busy");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_id();
    t_prot();
    t_prog();
    t_abort();
    @(posedge clk) t_busy();
    final_report();
  end
  // about 45 frames of roughly 1.2 us each
  initial begin
    #500us;
    err_count++;
    final_report();
  end
endmodule
